// *** hw/io_term_mapper.sv ***
// Programmable input/output terminal mapper with a classic Wishbone slave
`timescale 1ns/1ps
module io_term_mapper
(
  // Clock and reset
  input  wire  logic                      clk_i,
  input  wire  logic                      rst_i,
  // Wishbone slave
  input  wire  logic                      cyc_i,
  input  wire  logic                      stb_i,
  input  wire  logic                      we_i,
  input  wire  logic [7:0]                adr_i,
  input  wire  logic [3:0]                sel_i,
  input  wire  logic [31:0]               dat_i,
  output logic                            ack_o,
  output logic [31:0]                     dat_o,
  // Terminals
  input  wire  logic [7:0]                term_in_i,
  output logic [4:0]                      term_out_o,
  // Drive side
  input  wire  logic                      pos_mode_i,
  input  wire  io_term_pkg::drive_status_t status_i,
  output io_term_pkg::drive_cmd_t         cmd_o
);
  import io_term_pkg::*;

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [8:0]  in_pend  [NUM_IN];   // Software-written pending settings
  logic [8:0]  in_live  [NUM_IN];   // Settings in force
  logic [8:0]  out_pend [NUM_OUT];
  logic [8:0]  out_live [NUM_OUT];
  logic [7:0]  sync1;               // First synchroniser stage
  logic [7:0]  sync2;               // Second synchroniser stage
  logic [7:0]  act_prev;            // Active levels one cycle back
  logic [7:0]  active;              // Polarity-corrected active levels
  logic [2:0]  events;              // Sticky: origin, clear, alarm reset
  logic        applied;             // Settings copied since reset
  logic        apply_req;           // Restart-apply request pulse
  logic        wb_hit;              // Request not yet answered
  logic [2:0]  ev_clr;              // Event bits cleared by software
  drive_cmd_t  next_cmd;            // Decoded commands before the register
  logic [4:0]  next_out;            // Output pin levels before the register
  logic [4:0]  out_act;             // Selected status per output, before polarity

  // Active level test for one code across all inputs
  function automatic logic lvl(input logic [5:0] code, input logic [7:0] act,
                               input logic [8:0] cfg [NUM_IN]);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NUM_IN; i++)
      if (cfg[i][CODE_LSB +: CODE_W] == code && act[i])
        r = 1'b1;
    return r;
  endfunction : lvl

  // Status bit for one output code, reserved codes read inactive
  function automatic logic out_sel(input logic [5:0] code, input drive_status_t s);
    logic r;
    r = 1'b0;
    case (code)
      6'h00: r = s.ready & ~s.fault;  // R14
      6'h01: r = s.servo_on;          // R15
      6'h02: r = s.rot_detect;        // R16
      6'h03: r = s.speed_reach;       // R17
      6'h04: r = s.pos_done;          // R17
      6'h05: r = s.torque_limit;      // R19
      6'h06: r = s.fault;             // R18
      6'h07: r = s.brake;             // R18
      6'h08: r = s.overload;          // R18
      6'h09: r = s.speed_limit;       // R19
      6'h0B: r = s.dev_warn;          // R20
      6'h0C: r = s.home_done;         // R21
      6'h10: r = s.dyn_brake;         // R22
      default: r = 1'b0;              // R23
    endcase
    return r;
  endfunction : out_sel

  // Output setting index from a byte address inside the output window
  function automatic logic [2:0] out_idx(input logic [7:0] adr);
    logic [7:0] off;
    off = adr - ADDR_OUT_FUNC0;
    return off[4:2];
  endfunction : out_idx

  // ****************************************************************
  // Input synchroniser
  // ****************************************************************
  // Two stages before any logic reads the pins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end
    else
    begin
      sync1 <= term_in_i;
      sync2 <= sync1;
    end
  end

  // Contact polarity: 1 closed (high) active, 0 open (low) active
  always_comb
  begin
    for (int i = 0; i < NUM_IN; i++)
      active[i] = in_live[i][POL_BIT] ? sync2[i] : ~sync2[i];  // R2
  end

  // Previous active levels for edge detection; clean after reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      act_prev <= 8'h00;
    else
      act_prev <= active;
  end

  // ****************************************************************
  // Input function decode
  // ****************************************************************
  always_comb
  begin
    logic [7:0] rise;
    rise = active & ~act_prev;
    next_cmd               = '0;
    next_cmd.alarm_reset   = lvl(FI_ALM_RST, rise, in_live);                 // R4
    next_cmd.dev_clear     = lvl(FI_DEV_CLR, rise, in_live) & pos_mode_i;    // R5
    next_cmd.origin        = lvl(FI_ORIGIN, rise, in_live);                  // R9
    next_cmd.pulse_inhibit = lvl(FI_PLS_INH, active, in_live) & pos_mode_i;  // R6
    next_cmd.estop         = lvl(FI_ESTOP, active, in_live);                 // R7
    next_cmd.rev_inhibit   = lvl(FI_REV_INH, active, in_live);               // R7
    next_cmd.fwd_inhibit   = lvl(FI_FWD_INH, active, in_live);               // R8
    next_cmd.jog_fwd       = lvl(FI_JOG_FWD, active, in_live);               // R10
    next_cmd.jog_rev       = lvl(FI_JOG_REV, active, in_live);               // R10
    next_cmd.overheat      = lvl(FI_HOT, active, in_live);                   // R10
    next_cmd.gain_sel      = lvl(FI_GAIN, active, in_live);
    next_cmd.gear_sel      = lvl(FI_GEAR, active, in_live);                  // R11
    next_cmd.probe1        = lvl(FI_PROBE1, active, in_live);                // R11
    next_cmd.probe2        = lvl(FI_PROBE2, active, in_live);                // R11
  end

  // Commands registered toward the motion core; reserved codes match nothing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cmd_o <= '0;
    else
      cmd_o <= next_cmd;  // R1 R23
  end

  // ****************************************************************
  // Output mapping
  // ****************************************************************
  always_comb
  begin
    for (int k = 0; k < NUM_OUT; k++)
    begin
      out_act[k]  = out_sel(out_live[k][CODE_LSB +: CODE_W], status_i);
      // Open contact drives high when active; closed contact inverts
      next_out[k] = out_live[k][POL_BIT] ? out_act[k] : ~out_act[k];  // R13
    end
  end

  // Four general outputs plus the alarm output, from flip-flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      term_out_o <= 5'h00;
    else
      term_out_o <= next_out;  // R12
  end

  // ****************************************************************
  // Settings: pending copy written by software, live copy at restart
  // ****************************************************************
  // Live copy loads once per reset release, or on explicit apply request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      applied <= 1'b0;
    else if (!applied || apply_req)
      applied <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < NUM_IN; i++)
        in_live[i] <= IN_SET_RST;
      for (int k = 0; k < NUM_OUT; k++)
        out_live[k] <= OUT_SET_RST;
    end
    else if (!applied || apply_req)
    begin
      in_live  <= in_pend;   // R3
      out_live <= out_pend;  // R3
    end
  end

  // Request seen on the bus and not yet answered
  assign wb_hit = cyc_i & stb_i & ~ack_o;

  // Writes land at the edge where the master samples ack high
  wire wr_ok = cyc_i & stb_i & we_i & ack_o & sel_i[0];

  // Pending input settings: reset gives reserved codes, so nothing undefined goes live
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < NUM_IN; i++)
        in_pend[i] <= IN_SET_RST;
    end
    else if (wr_ok && adr_i < ADDR_OUT_FUNC0 && adr_i[1:0] == 2'b00)
      in_pend[adr_i[4:2]] <= {sel_i[1] ? dat_i[8] : in_pend[adr_i[4:2]][8], dat_i[7:0]};
  end

  // Pending output settings, alarm output at index 4
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int k = 0; k < NUM_OUT; k++)
        out_pend[k] <= OUT_SET_RST;
    end
    else if (wr_ok && adr_i >= ADDR_OUT_FUNC0 && adr_i < ADDR_OUT_FUNC0 + 8'h14 && adr_i[1:0] == 2'b00)
      out_pend[out_idx(adr_i)] <= {sel_i[1] ? dat_i[8] : out_pend[out_idx(adr_i)][8], dat_i[7:0]};
  end

  // Apply request pulse from software restart
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      apply_req <= 1'b0;
    else
      apply_req <= wr_ok & (adr_i == ADDR_APPLY) & dat_i[0];
  end

  // ****************************************************************
  // Sticky edge events; a new edge wins over a clear
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      events <= 3'h0;
    else
      events <= (events & ~ev_clr) | {next_cmd.origin, next_cmd.dev_clear, next_cmd.alarm_reset};
  end

  // Bits written as ones clear the matching events
  assign ev_clr = (wr_ok && adr_i == ADDR_EVENTS) ? dat_i[2:0] : 3'h0;

  // ****************************************************************
  // Wishbone answer: ack one cycle after the request, then drop
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= wb_hit;
  end

  // Read data registered together with the ack, held until the next read request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0000_0000;
    else if (wb_hit && !we_i)
    begin
      if (adr_i < ADDR_OUT_FUNC0)
        dat_o <= {23'h0, in_pend[adr_i[4:2]]};
      else if (adr_i < ADDR_OUT_FUNC0 + 8'h14)
        dat_o <= {23'h0, out_pend[out_idx(adr_i)]};
      else if (adr_i == ADDR_IN_STATE)
        dat_o <= {16'h0, active, sync2};
      else if (adr_i == ADDR_OUT_STATE)
        dat_o <= {19'h0, out_act, 3'h0, term_out_o};
      else if (adr_i == ADDR_EVENTS)
        dat_o <= {29'h0, events};
      else if (adr_i == ADDR_APPLIED)
        dat_o <= {31'h0, applied};
      else
        dat_o <= 32'h0000_0000;  // Unmapped reads zero
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Ack is a single-cycle answer
  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

  // Every open request is answered at the next edge
  property p_ack_answer;
    @(posedge clk_i) disable iff (rst_i) wb_hit |=> ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered");

  // Alarm reset is a one-cycle pulse per activation
  property p_alarm_reset_edge;
    @(posedge clk_i) disable iff (rst_i) cmd_o.alarm_reset |=> !cmd_o.alarm_reset;
  endproperty
  a_alarm_reset_edge: assert property (p_alarm_reset_edge) else $error("alarm reset not a pulse");  // R4

  // Alarm reset pulse is also kept as a sticky event
  property p_alarm_event;
    @(posedge clk_i) disable iff (rst_i) cmd_o.alarm_reset |-> events[0];
  endproperty
  a_alarm_event: assert property (p_alarm_event) else $error("alarm reset event lost");  // R4

  // Deviation clear only in position mode
  property p_dev_clear_mode;
    @(posedge clk_i) disable iff (rst_i) cmd_o.dev_clear |-> $past(pos_mode_i);
  endproperty
  a_dev_clear_mode: assert property (p_dev_clear_mode) else $error("clear outside position mode");  // R5

  // Deviation clear is a one-cycle pulse per activation
  property p_dev_clear_pulse;
    @(posedge clk_i) disable iff (rst_i) cmd_o.dev_clear |=> !cmd_o.dev_clear;
  endproperty
  a_dev_clear_pulse: assert property (p_dev_clear_pulse) else $error("deviation clear not a pulse");  // R5

  // Pulse inhibit only in position mode
  property p_inhibit_mode;
    @(posedge clk_i) disable iff (rst_i) !$past(pos_mode_i) |-> !cmd_o.pulse_inhibit;
  endproperty
  a_inhibit_mode: assert property (p_inhibit_mode) else $error("inhibit outside position mode");  // R6

  // Input 0 setting in force changes only at a restart
  property p_live_stable;
    @(posedge clk_i) disable iff (rst_i) applied && !apply_req |=> $stable(in_live[0]);
  endproperty
  a_live_stable: assert property (p_live_stable) else $error("setting changed without restart");  // R3

  // Alarm output setting in force changes only at a restart
  property p_out_live_stable;
    @(posedge clk_i) disable iff (rst_i) applied && !apply_req |=> $stable(out_live[4]);
  endproperty
  a_out_live_stable: assert property (p_out_live_stable) else $error("output setting changed early");  // R3

  // First output follows its selected status with the contact type in force
  property p_out_map;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> term_out_o[0] == ($past(out_live[0][POL_BIT]) ? $past(out_act[0]) : !$past(out_act[0]));
  endproperty
  a_out_map: assert property (p_out_map) else $error("output polarity wrong");  // R13

  // Alarm output with the reserved code rests at its inactive level
  property p_alarm_reserved;
    @(posedge clk_i) disable iff (rst_i)
      out_live[4][CODE_LSB +: CODE_W] == 6'h0A |=> term_out_o[4] == !$past(out_live[4][POL_BIT]);
  endproperty
  a_alarm_reserved: assert property (p_alarm_reserved) else $error("reserved output active");  // R23

  // Origin pulse is kept as a sticky event
  property p_event_sticky;
    @(posedge clk_i) disable iff (rst_i) cmd_o.origin |-> events[2];
  endproperty
  a_event_sticky: assert property (p_event_sticky) else $error("origin event lost");  // R9

  // Origin is a one-cycle pulse per activation
  property p_origin_pulse;
    @(posedge clk_i) disable iff (rst_i) cmd_o.origin |=> !cmd_o.origin;
  endproperty
  a_origin_pulse: assert property (p_origin_pulse) else $error("origin not a pulse");  // R9

  // Emergency stop level reaches the motion core
  property p_estop;
    @(posedge clk_i) disable iff (rst_i) next_cmd.estop |=> cmd_o.estop;
  endproperty
  a_estop: assert property (p_estop) else $error("estop not passed");  // R7

endmodule : io_term_mapper

// *** hw/io_term_pkg.sv ***
// Package with constants and types for the programmable terminal mapper
// Notes on behaviour
// R1 - Eight input terminals, each with function code
// R2 - Input polarity: 0 open active, 1 closed
// R3 - New assignments apply only after restart
// R4 - Code 1 edge pulses alarm reset
// R5 - Code 10 edge clears deviation in position
// R6 - Code 11 level inhibits pulses in position
// R7 - Code 12 emergency stop, 13 reverse inhibit
// R8 - Code 14 level forbids forward rotation
// R9 - Code 22 edge gives external origin
// R10 - Codes 26,27 jog, 28 overheat, levels
// R11 - Code 33 gear select, 34/35 probes
// R12 - Four general outputs plus alarm output
// R13 - Output polarity: 0 closed, 1 open
// R14 - Output code 0: ready and fault free
// R15 - Output code 1: servo on
// R16 - Output code 2: speed above threshold
// R17 - Code 3 speed reached, 4 position done
// R18 - Code 6 fault, 7 brake, 8 overload
// R19 - Code 5 torque limit, 9 speed limit
// R20 - Code 11 large deviation warning
// R21 - Code 12 homing complete
// R22 - Code 16 dynamic braking
// R23 - Reserved codes do nothing, outputs inactive
package io_term_pkg;

  // ****************************************************************
  // Register map (word byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_IN_FUNC0  = 8'h00;  // Input setting 0, 1..7 follow every 4
  localparam logic [7:0] ADDR_OUT_FUNC0 = 8'h20;  // Output setting 0..3, 4 is the alarm output
  localparam logic [7:0] ADDR_IN_STATE  = 8'h40;  // Raw and active input levels
  localparam logic [7:0] ADDR_OUT_STATE = 8'h44;  // Output levels and active flags
  localparam logic [7:0] ADDR_EVENTS    = 8'h48;  // Sticky edge events, write one to clear
  localparam logic [7:0] ADDR_APPLIED   = 8'h4C;  // Bit 0: settings applied since reset
  localparam logic [7:0] ADDR_APPLY     = 8'h50;  // Write bit 0 = restart-apply request

  // ****************************************************************
  // Setting fields: code in [5:0], contact type in bit 8
  // ****************************************************************
  localparam int unsigned CODE_LSB  = 0;
  localparam int unsigned CODE_W    = 6;
  localparam int unsigned POL_BIT   = 8;
  localparam logic [8:0] IN_SET_RST  = 9'h100;  // Reserved code, closed active
  localparam logic [8:0] OUT_SET_RST = 9'h10A;  // Reserved code 10, open contact

  localparam int unsigned NUM_IN  = 8;
  localparam int unsigned NUM_OUT = 5;

  // Input function codes
  localparam logic [5:0] FI_ALM_RST = 6'h01;
  localparam logic [5:0] FI_GAIN    = 6'h08;
  localparam logic [5:0] FI_DEV_CLR = 6'h0A;
  localparam logic [5:0] FI_PLS_INH = 6'h0B;
  localparam logic [5:0] FI_ESTOP   = 6'h0C;
  localparam logic [5:0] FI_REV_INH = 6'h0D;
  localparam logic [5:0] FI_FWD_INH = 6'h0E;
  localparam logic [5:0] FI_ORIGIN  = 6'h16;
  localparam logic [5:0] FI_JOG_FWD = 6'h1A;
  localparam logic [5:0] FI_JOG_REV = 6'h1B;
  localparam logic [5:0] FI_HOT     = 6'h1C;
  localparam logic [5:0] FI_GEAR    = 6'h21;
  localparam logic [5:0] FI_PROBE1  = 6'h22;
  localparam logic [5:0] FI_PROBE2  = 6'h23;

  // Internal drive status, one bit per output function code 0..16 except reserved codes 10 and 13..15
  typedef struct packed {
    logic dyn_brake;    // 16
    logic home_done;    // 12
    logic dev_warn;     // 11
    logic speed_limit;  // 9
    logic overload;     // 8
    logic brake;        // 7
    logic fault;        // 6
    logic torque_limit; // 5
    logic pos_done;     // 4
    logic speed_reach;  // 3
    logic rot_detect;   // 2
    logic servo_on;     // 1
    logic ready;        // 0
  } drive_status_t;

  // Commands handed to the motion core
  typedef struct packed {
    logic alarm_reset;   // Pulse
    logic dev_clear;     // Pulse, already gated by position mode
    logic origin;        // Pulse
    logic pulse_inhibit; // Level, gated by position mode
    logic estop;
    logic rev_inhibit;
    logic fwd_inhibit;
    logic jog_fwd;
    logic jog_rev;
    logic overheat;
    logic gain_sel;
    logic gear_sel;
    logic probe1;
    logic probe2;
  } drive_cmd_t;

endpackage : io_term_pkg

// *** verif/term_switch_model.sv ***
// Model of the external switches wired to the input terminals
`timescale 1ns/1ps
module term_switch_model
(
  // Wanted switch state and wiring of each terminal
  input  wire logic [7:0] active_i,
  input  wire logic [7:0] pol_i,
  // Terminal pins
  output logic      [7:0] term_o
);
  // Closed-active wiring gives a high pin when active, open-active a low pin
  always_comb term_o = ~(active_i ^ pol_i);
endmodule : term_switch_model

// *** verif/programmable_io_terminal_mapper_tb_top.sv ***
// Self-checking testbench for the terminal mapper
`timescale 1ns/1ps
module programmable_io_terminal_mapper_tb_top;
  import io_term_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic          clk_i;
  logic          rst_i;
  logic          cyc, stb, we, ack;
  logic [7:0]    adr;
  logic [3:0]    sel;
  logic [31:0]   wdat, rdat, q;
  logic [7:0]    term_in, act, pol;
  logic [4:0]    term_out;
  logic          pos_mode;
  drive_status_t status;
  drive_cmd_t    cmd;
  int            err_count, check_count;
  // Input codes tried in turn, two reserved ones last
  logic [5:0]    codes [16] = '{FI_ALM_RST, FI_GAIN, FI_DEV_CLR, FI_PLS_INH, FI_ESTOP, FI_REV_INH, FI_FWD_INH,
                                FI_ORIGIN, FI_JOG_FWD, FI_JOG_REV, FI_HOT, FI_GEAR, FI_PROBE1, FI_PROBE2, 6'h09, 6'h1E};

  io_term_mapper i_io_term_mapper (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .ack_o(ack), .dat_o(rdat), .term_in_i(term_in), .term_out_o(term_out),
    .pos_mode_i(pos_mode), .status_i(status), .cmd_o(cmd));
  term_switch_model i_term_switch_model (.active_i(act), .pol_i(pol), .term_o(term_in));

  // Clock, 20 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ****************************************************************
  // Report and compare tasks
  // ****************************************************************
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic chk_cmd(input drive_cmd_t got, input drive_cmd_t exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_cmd

  // Classic single Wishbone cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
    begin
      err_count++;
      $display("[ERR] %0t bus cycle not answered", $time);
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // A pending assignment must wait for the restart request
  task automatic test_restart;
    drive_cmd_t e;
    e = '0;
    e.estop = 1'b1;
    wb(1'b1, ADDR_IN_FUNC0 + 8'h1C, {23'h0, 1'b1, 2'h0, FI_ESTOP}, q);
    act[7] <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk_cmd(cmd, '0, "pending setting acted");
    wb(1'b1, ADDR_APPLY, 32'h1, q);
    repeat (4) @(posedge clk_i);
    chk_cmd(cmd, e, "applied stop");
    wb(1'b0, ADDR_IN_STATE, 32'h0, q);
    chk_word(q, 32'h0000_8080, "input state");
    act[7] <= 1'b0;
    repeat (4) @(posedge clk_i);
    $display("Restart test done");
  endtask : test_restart

  // One input code on terminal i: idle, then held active for six cycles
  task automatic run_in(input int i, input logic [5:0] c, input logic pm);
    drive_cmd_t acc, e;
    int pc;
    e = '0;
    case (c)
      FI_ALM_RST: e.alarm_reset = 1'b1;
      FI_GAIN:    e.gain_sel = 1'b1;
      FI_DEV_CLR: e.dev_clear = pm;
      FI_PLS_INH: e.pulse_inhibit = pm;
      FI_ESTOP:   e.estop = 1'b1;
      FI_REV_INH: e.rev_inhibit = 1'b1;
      FI_FWD_INH: e.fwd_inhibit = 1'b1;
      FI_ORIGIN:  e.origin = 1'b1;
      FI_JOG_FWD: e.jog_fwd = 1'b1;
      FI_JOG_REV: e.jog_rev = 1'b1;
      FI_HOT:     e.overheat = 1'b1;
      FI_GEAR:    e.gear_sel = 1'b1;
      FI_PROBE1:  e.probe1 = 1'b1;
      FI_PROBE2:  e.probe2 = 1'b1;
      default:    e = '0;
    endcase
    pol[i] <= i[0];
    pos_mode <= pm;
    wb(1'b1, ADDR_IN_FUNC0 + 8'(4 * i), {23'h0, i[0], 2'h0, c}, q);
    wb(1'b1, ADDR_APPLY, 32'h1, q);
    repeat (5) @(posedge clk_i);
    chk_cmd(cmd, '0, "idle input acted");
    act[i] <= 1'b1;
    acc = '0;
    pc = 0;
    repeat (6)
    begin
      @(posedge clk_i);
      acc = acc | cmd;
      pc += int'(cmd.alarm_reset | cmd.dev_clear | cmd.origin);
    end
    chk_cmd(acc, e, "input function");
    chk_word(32'(pc), {31'h0, e.alarm_reset | e.dev_clear | e.origin}, "pulse count");
    act[i] <= 1'b0;
    repeat (4) @(posedge clk_i);
    $display("Input test code %0d done", c);
  endtask : run_in

  // One output code: its status alone, then every other status with ready held set
  task automatic run_out(input int c);
    int i, b;
    logic p, rsv;
    logic [12:0] overheat_input_alt;
    i = c % 5;
    rsv = (c == 10) || (c > 12 && c < 16);
    p = rsv | c[0];
    b = (c < 10) ? c : (c == 11) ? 10 : (c == 12) ? 11 : 12;
    overheat_input_alt = 13'h1 << b;
    wb(1'b1, ADDR_OUT_FUNC0 + 8'(4 * i), {23'h0, p, 2'h0, 6'(c)}, q);
    wb(1'b1, ADDR_APPLY, 32'h1, q);
    status <= drive_status_t'(overheat_input_alt);
    repeat (3) @(posedge clk_i);
    chk_word({31'h0, term_out[i]}, {31'h0, p & ~rsv}, "output active");
    status <= drive_status_t'(~overheat_input_alt | 13'h1);
    repeat (3) @(posedge clk_i);
    chk_word({31'h0, term_out[i]}, {31'h0, ~p}, "output inactive");
    $display("Output test code %0d done", c);
  endtask : run_out

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial
  begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, wdat, pos_mode, act} = '0;
    sel = 4'hF;
    status = '0;
    pol = 8'hFF;
    err_count = 0;
    check_count = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 8; k++) wb(1'b1, ADDR_IN_FUNC0 + 8'(4 * k), 32'h100, q);
    for (int k = 0; k < 5; k++) wb(1'b1, ADDR_OUT_FUNC0 + 8'(4 * k), 32'h10A, q);
    wb(1'b1, ADDR_APPLY, 32'h1, q);
    status <= drive_status_t'(13'h1FFF);
    repeat (4) @(posedge clk_i);
    chk_word({27'h0, term_out}, 32'h0, "reserved outputs");
    chk_cmd(cmd, '0, "reserved inputs");
    wb(1'b0, ADDR_APPLIED, 32'h0, q);
    chk_word(q, 32'h1, "applied flag");
    wb(1'b0, 8'h60, 32'h0, q);
    chk_word(q, 32'h0, "unmapped read");
    wb(1'b0, ADDR_OUT_STATE, 32'h0, q);
    chk_word(q, 32'h0, "output state");
    $display("Reset test done");
    test_restart;
    for (int k = 0; k < 16; k++) run_in(k % 8, codes[k], 1'b1);
    run_in(2, FI_DEV_CLR, 1'b0);
    run_in(3, FI_PLS_INH, 1'b0);
    wb(1'b0, ADDR_EVENTS, 32'h0, q);
    chk_word(q & 32'h7, 32'h7, "edge events");
    wb(1'b1, ADDR_EVENTS, 32'h7, q);
    wb(1'b0, ADDR_EVENTS, 32'h0, q);
    chk_word(q & 32'h7, 32'h0, "events cleared");
    $display("Event test done");
    for (int c = 0; c < 17; c++) run_out(c);
    test_done;
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done;
  end
endmodule : programmable_io_terminal_mapper_tb_top
